// ===== hdl/pcm_clock_manager.sv
// power and clock manager: peripheral gates, clock generator control, APB registers
`timescale 1ns/1ps
module pcm_clock_manager import pcm_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic backup_resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // clock inputs from pins and the analog macros
    input wire logic slow_clk_i,
    input wire logic osc_clk_i,
    input wire logic pll_clk_i,
    // backup-domain pins
    input wire logic wake_pin_i,
    input wire logic rtc_alarm_i,
    // controls and status
    output logic [31:0] periph_clk_en_o,
    output logic main_oscillator_on_o,
    output logic oscillator_bypass_o,
    output logic [5:0] pll_factor_o,
    output logic master_clk_o,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_o,
    output logic power_off_alarm_pin_o,
    output logic power_off_alarm_pin_oe_o,
    output logic oscillator_stable_flag_o,
    output logic pll_lock_o
);
    // ======================================================================
    // state
    typedef struct packed {
        logic [31:0] periph_clk;
        pcm_clk_cfg_s cfg;
        logic [7:0] osc_cnt;
        logic [2:0] osc_tick;
        logic [5:0] pll_cnt;
        logic osc_stable;
        logic pll_lock;
        logic slow_prev;
        logic src_prev;
        logic [5:0] div_cnt;
        logic mclk;
        logic [31:0] rdata;
        logic err;
    } pcm_main_st_s;

    pcm_main_st_s q;
    pcm_main_st_s d;

    logic [2:0] clk_s;
    logic setup;
    logic access;
    logic wr;
    logic slow_rise;
    logic src;
    logic src_rise;
    logic osc_usable;
    logic [31:0] wmask;
    pcm_clk_cfg_s wcfg;
    pcm_power_mode_s pmode;
    pcm_power_wr_s pwr_wr;

    // ======================================================================
    // pin clocks are sampled, never used as clocks here
    pcm_sync #(.W(3)) u_clk_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i({pll_clk_i, osc_clk_i, slow_clk_i}),
        .sync_o(clk_s)
    );

    // ======================================================================
    // backup-powered alarm pin logic; it keeps its state over a main reset
    pcm_power_ctl u_power (
        .clk_i(clk_i),
        .backup_resetn_i(backup_resetn_i),
        .wr_i(pwr_wr),
        .wake_pin_i(wake_pin_i),
        .rtc_alarm_i(rtc_alarm_i),
        .mode_o(pmode),
        .pin_o(power_off_alarm_pin_o),
        .pin_oe_o(power_off_alarm_pin_oe_o)
    );

    // ======================================================================
    // bus decode
    assign setup = psel_i & ~penable_i;
    assign access = psel_i & penable_i;
    assign wr = access & pwrite_i;
    assign wmask = pwdata_i & PERIPH_MASK; // see R25
    assign wcfg = pcm_clk_cfg_s'(pwdata_i & CLK_GEN_CFG_MASK);

    always_comb begin
        pwr_wr.cmd_we = wr && (paddr_i == OFF_POWER_CMD);
        pwr_wr.mode_we = wr && (paddr_i == OFF_POWER_MODE);
        pwr_wr.data = pwdata_i[7:0];
    end

    // ======================================================================
    // next state
    always_comb begin
        d = q;

        // peripheral clock gates act on the write edge itself
        if (wr && paddr_i == OFF_CLK_ENABLE) begin
            d.periph_clk = q.periph_clk | wmask; // see R1 see R24
        end
        if (wr && paddr_i == OFF_CLK_DISABLE) begin
            d.periph_clk = q.periph_clk & ~wmask; // see R2 see R24
        end

        if (wr && paddr_i == OFF_CLK_GEN_CFG) begin
            d.cfg = wcfg;
        end

        // slow clock tick and its divide-by-8 for the oscillator timer
        d.slow_prev = clk_s[0];
        slow_rise = clk_s[0] & ~q.slow_prev;
        if (slow_rise) begin
            d.osc_tick = q.osc_tick + 3'h1;
        end

        // oscillator start-up timer
        if (slow_rise && q.osc_tick == OSC_TICK_LAST && q.osc_cnt != 8'h00) begin
            d.osc_cnt = q.osc_cnt - 8'h01;
        end
        if (d.cfg.main_oscillator_on && !q.cfg.main_oscillator_on
            && d.cfg.osc_startup_count != 8'h00) begin
            d.osc_cnt = d.cfg.osc_startup_count; // see R10
        end
        // a stopped oscillator forgets any half-done count
        if (!d.cfg.main_oscillator_on) begin
            d.osc_cnt = 8'h00;
        end
        d.osc_stable = d.cfg.main_oscillator_on && (d.osc_cnt == 8'h00); // see R22

        // PLL lock timer, counted in whole slow clock periods
        if (slow_rise && q.pll_cnt != 6'h00) begin
            d.pll_cnt = q.pll_cnt - 6'h01;
        end
        if (d.cfg.pll_factor != q.cfg.pll_factor && d.cfg.pll_factor != 6'h00
            && d.cfg.pll_settle_count != 6'h00) begin
            d.pll_cnt = d.cfg.pll_settle_count; // see R11
        end
        if (d.cfg.pll_factor == 6'h00) begin
            d.pll_cnt = 6'h00; // see R8
        end
        // a bypassed input counts as a settled reference for the PLL
        d.pll_lock = (d.cfg.pll_factor != 6'h00) && (d.pll_cnt == 6'h00)
            && (d.osc_stable || d.cfg.oscillator_bypass); // see R23

        // source select; an unsettled source is held low to avoid runt edges
        osc_usable = q.osc_stable | q.cfg.oscillator_bypass; // see R4
        unique case (q.cfg.clock_source_select) // see R9
            SRC_SLOW: src = clk_s[0];
            SRC_OSC: src = clk_s[1] & osc_usable;
            SRC_PLL: src = clk_s[2] & q.pll_lock;
            SRC_RSV: src = 1'b0;
        endcase

        // prescaler: bit n-1 of an edge counter divides by 2 to the n
        d.src_prev = src;
        src_rise = src & ~q.src_prev;
        if (src_rise) begin
            d.div_cnt = q.div_cnt + 6'h01;
        end
        unique case (q.cfg.clock_divider_select) // see R7
            3'h0: d.mclk = src;
            3'h7: d.mclk = 1'b0;
            default: d.mclk = q.div_cnt[q.cfg.clock_divider_select - 3'h1];
        endcase

        // read data is latched in the setup cycle, so the access is zero-wait
        if (setup) begin
            d.rdata = 32'h0000_0000;
            d.err = 1'b0;
            unique case (paddr_i)
                OFF_CLK_ENABLE, OFF_CLK_DISABLE, OFF_POWER_CMD: d.rdata = 32'h0000_0000;
                OFF_CLK_STATE: d.rdata = q.periph_clk; // see R3
                OFF_CLK_GEN_CFG: d.rdata = q.cfg;
                OFF_POWER_MODE: d.rdata = {24'h00_0000, pmode};
                OFF_STATUS_FLAGS: begin
                    d.rdata[STAT_OSC_BIT] = q.osc_stable;
                    d.rdata[STAT_LOCK_BIT] = q.pll_lock;
                end
                default: d.err = 1'b1;
            endcase
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.periph_clk <= CLK_STATE_RST; // see R24
            q.cfg <= pcm_clk_cfg_s'(CLK_GEN_CFG_RST);
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // outputs
    assign prdata_o = q.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = q.err;
    assign periph_clk_en_o = q.periph_clk;
    assign main_oscillator_on_o = q.cfg.main_oscillator_on;
    assign oscillator_bypass_o = q.cfg.oscillator_bypass;
    assign pll_factor_o = q.cfg.pll_factor;
    assign master_clk_o = q.mclk;
    assign clock_output_pin_o = q.mclk;
    assign clock_output_pin_oe_o = ~q.cfg.clock_output_off; // see R6
    assign oscillator_stable_flag_o = q.osc_stable;
    assign pll_lock_o = q.pll_lock;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_write(logic [7:0] addr);
        wr && paddr_i == addr;
    endsequence

    sequence s_setup_read(logic [7:0] addr);
        setup && !pwrite_i && paddr_i == addr;
    endsequence

    a_enable_sets_bits: assert property ( // see R1
        s_write(OFF_CLK_ENABLE) |=> ((periph_clk_en_o & $past(wmask)) == $past(wmask)))
        else $error("clock enable write did not start clocks");

    a_disable_clr_bits: assert property ( // see R2
        s_write(OFF_CLK_DISABLE) |=> ((periph_clk_en_o & $past(wmask)) == 32'h0000_0000))
        else $error("clock disable write did not stop clocks");

    a_enable_zero_keeps: assert property ( // see R1
        (s_write(OFF_CLK_ENABLE) or s_write(OFF_CLK_DISABLE)) |=>
        ((periph_clk_en_o & ~$past(wmask)) == ($past(periph_clk_en_o) & ~$past(wmask))))
        else $error("zero bits changed a peripheral clock");

    a_state_readback: assert property ( // see R3
        s_setup_read(OFF_CLK_STATE) ##1 access |-> prdata_o == periph_clk_en_o)
        else $error("clock state read does not match gates");

    a_unused_bits_zero: assert property ( // see R25
        (periph_clk_en_o & ~PERIPH_MASK) == 32'h0000_0000)
        else $error("unassigned peripheral bit is set");

    a_osc_preload: assert property ( // see R10
        $rose(q.cfg.main_oscillator_on) && q.cfg.osc_startup_count != 8'h00
        |-> q.osc_cnt == q.cfg.osc_startup_count && !oscillator_stable_flag_o)
        else $error("oscillator counter not preloaded");

    a_osc_off_clears: assert property ( // see R22
        !main_oscillator_on_o |-> !oscillator_stable_flag_o && q.osc_cnt == 8'h00)
        else $error("stable flag set with oscillator off");

    a_osc_flag_sets: assert property ( // see R22
        main_oscillator_on_o && q.osc_cnt == 8'h01 && slow_rise && q.osc_tick == OSC_TICK_LAST
        |=> oscillator_stable_flag_o)
        else $error("stable flag late after count end");

    a_pll_preload: assert property ( // see R11
        ($changed(q.cfg.pll_factor) && q.cfg.pll_factor != 6'h00
         && q.cfg.pll_settle_count != 6'h00) |-> (q.pll_cnt == q.cfg.pll_settle_count && !pll_lock_o))
        else $error("lock counter not preloaded");

    a_pll_off_unlock: assert property ( // see R8
        pll_factor_o == 6'h00 |-> !pll_lock_o)
        else $error("lock flag set with PLL off");

    a_lock_needs_ref: assert property ( // see R23
        pll_lock_o |-> (oscillator_stable_flag_o || oscillator_bypass_o) && q.pll_cnt == 6'h00)
        else $error("lock flag without a settled reference");

    a_clk_out_float: assert property ( // see R6
        $rose(q.cfg.clock_output_off) |-> !clock_output_pin_oe_o ##1 !clock_output_pin_oe_o)
        else $error("clock output pin driven while off");

    a_div2_follows: assert property ( // see R7
        q.cfg.clock_divider_select == 3'h1 && src_rise && $stable(q.cfg.clock_divider_select)
        |=> master_clk_o == $past(q.div_cnt[0]))
        else $error("divide-by-two output did not toggle");

    a_reserved_src_low: assert property ( // see R9
        q.cfg.clock_source_select == SRC_RSV [*2] |=> !master_clk_o)
        else $error("reserved source produced a clock");

    a_bad_addr_error: assert property (
        setup && paddr_i[1:0] != 2'b00 |=> pslverr_o)
        else $error("misaligned address not refused");
endmodule : pcm_clock_manager

// ===== hdl/pcm_pkg.sv
// package: register map, field layouts and types of the power and clock manager
package pcm_pkg;
// ==========================================================================
// Summary of operation
// R1 - a one in the clock-enable register starts that peripheral clock; zero does nothing
// R2 - a one in the clock-disable register stops that peripheral clock; zero does nothing
// R3 - clock state register reads one per running clock, all zeros after reset
// R4 - bypass bit picks crystal when zero, external clock on input pin when one
// R5 - software never sets oscillator enable and bypass together
// R6 - clock output pin carries master clock unless the output-off bit floats it
// R7 - divider codes 0 to 6 divide by 1, 2, 4 up to 64; code 7 reserved
// R8 - factor zero turns the PLL off; 1 to 63 multiply by factor plus one
// R9 - source field 15:14 picks slow clock, main oscillator or PLL; 3 reserved
// R10 - enabling the oscillator loads its counter from a nonzero count, in slow/8 periods
// R11 - changing the PLL factor loads the lock counter when factor and count are nonzero
// R12 - software programs the PLL lock count with at least 2
// R13 - power-off command drives the alarm pin per the power-off selection
// R14 - wake-ack command drives the alarm pin per the wake-ack selection
// R15 - both commands in one write: the wake-ack state wins
// R16 - power-off selection bits 1:0 give high-z, low, high; 3 reserved
// R17 - wake-ack selection bits 3:2 give high-z, low, high; 3 reserved
// R18 - alarm wake enable bit 4 lets an alarm cause a wake-up
// R19 - alarm power-off bit 5 lets an alarm power off, only without alarm wake
// R20 - wake edge bits 7:6 detect none, rising, falling or both edges
// R21 - only the backup reset sets the power mode register, to 0x1
// R22 - oscillator stable flag sets at counter zero, clears when off or settling
// R23 - lock flag sets at counter zero, clears while oscillator or PLL unsettled
// R24 - peripheral clocks stop and restart at once and are off after reset
// R25 - unassigned peripheral bits ignore writes and read zero
// R26 - software avoids reserved codes in divider, source and pin selections

// ==========================================================================
// register offsets (byte addresses)
localparam logic [7:0] OFF_CLK_ENABLE = 8'h10;
localparam logic [7:0] OFF_CLK_DISABLE = 8'h14;
localparam logic [7:0] OFF_CLK_STATE = 8'h18;
localparam logic [7:0] OFF_CLK_GEN_CFG = 8'h20;
localparam logic [7:0] OFF_POWER_CMD = 8'h28;
localparam logic [7:0] OFF_POWER_MODE = 8'h2c;
localparam logic [7:0] OFF_STATUS_FLAGS = 8'h30;

// ==========================================================================
// reset values, masks, field positions, timing
localparam logic [31:0] CLK_STATE_RST = 32'h0000_0000;
localparam logic [31:0] CLK_GEN_CFG_RST = 32'h0000_0000;
localparam logic [7:0] POWER_MODE_RST = 8'h01;
localparam logic [31:0] PERIPH_MASK = 32'h0007_effc;
localparam logic [31:0] CLK_GEN_CFG_MASK = 32'h3fff_ff77;
localparam int PCMD_POWER_OFF_BIT = 0;
localparam int PCMD_WAKE_ACK_BIT = 1;
localparam int STAT_OSC_BIT = 0;
localparam int STAT_LOCK_BIT = 1;
localparam logic [2:0] OSC_TICK_LAST = 3'h7;

// ==========================================================================
// encodings and carriers
typedef enum logic [1:0] {
    SRC_SLOW = 2'h0,
    SRC_OSC = 2'h1,
    SRC_PLL = 2'h2,
    SRC_RSV = 2'h3
} pcm_src_e;

typedef enum logic [1:0] {
    DRV_HIZ = 2'h0,
    DRV_LOW = 2'h1,
    DRV_HIGH = 2'h2,
    DRV_RSV = 2'h3
} pcm_drive_e;

typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
} pcm_edge_e;

typedef struct packed {
    logic [1:0] rsv_hi;
    logic [5:0] pll_settle_count;
    logic [7:0] osc_startup_count;
    pcm_src_e clock_source_select;
    logic [5:0] pll_factor;
    logic rsv_7;
    logic [2:0] clock_divider_select;
    logic rsv_3;
    logic clock_output_off;
    logic main_oscillator_on;
    logic oscillator_bypass;
} pcm_clk_cfg_s;

typedef struct packed {
    pcm_edge_e wake_edge_select;
    logic alarm_power_off_enable;
    logic alarm_wake_enable;
    pcm_drive_e wake_ack_output_select;
    pcm_drive_e power_off_output_select;
} pcm_power_mode_s;

typedef struct packed {
    logic cmd_we;
    logic mode_we;
    logic [7:0] data;
} pcm_power_wr_s;

endpackage : pcm_pkg

// ===== hdl/pcm_sync.sv
// two-flop synchroniser for levels entering from pins
`timescale 1ns/1ps
module pcm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } pcm_sync_st_s;

    pcm_sync_st_s q;
    pcm_sync_st_s d;

    always_comb begin
        d.meta = async_i;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.sync;
endmodule : pcm_sync

// ===== hdl/pcm_power_ctl.sv
// battery-backed power-off / wake-up logic driving the alarm pin
`timescale 1ns/1ps
module pcm_power_ctl import pcm_pkg::*; (
    input wire logic clk_i,
    input wire logic backup_resetn_i,
    input wire pcm_power_wr_s wr_i,
    input wire logic wake_pin_i,
    input wire logic rtc_alarm_i,
    output pcm_power_mode_s mode_o,
    output logic pin_o,
    output logic pin_oe_o
);
    typedef struct packed {
        pcm_power_mode_s mode;
        logic wake_prev;
        logic alarm_prev;
        logic pin;
        logic pin_oe;
    } pcm_pwr_st_s;

    pcm_pwr_st_s q;
    pcm_pwr_st_s d;
    logic [1:0] ins_s;
    logic wake_hit;
    logic alarm_hit;
    logic go;
    pcm_drive_e sel;

    pcm_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .resetn_i(backup_resetn_i),
        .async_i({rtc_alarm_i, wake_pin_i}),
        .sync_o(ins_s)
    );

    always_comb begin
        d = q;
        d.wake_prev = ins_s[0];
        d.alarm_prev = ins_s[1];
        alarm_hit = ins_s[1] & ~q.alarm_prev;
        unique case (q.mode.wake_edge_select) // see R20
            EDGE_NONE: wake_hit = 1'b0;
            EDGE_RISE: wake_hit = ins_s[0] & ~q.wake_prev;
            EDGE_FALL: wake_hit = ~ins_s[0] & q.wake_prev;
            EDGE_BOTH: wake_hit = ins_s[0] ^ q.wake_prev;
        endcase
        if (wr_i.mode_we) begin
            d.mode = pcm_power_mode_s'(wr_i.data);
        end
        go = 1'b0;
        sel = DRV_HIZ;
        if ((wr_i.cmd_we && wr_i.data[PCMD_POWER_OFF_BIT])
            || (alarm_hit && !q.mode.alarm_wake_enable && q.mode.alarm_power_off_enable)) begin // see R13 see R19
            go = 1'b1;
            sel = q.mode.power_off_output_select;
        end
        // wake-ack comes last so it wins a tie against power-off, whether each comes from a command or a pin event
        if ((wr_i.cmd_we && wr_i.data[PCMD_WAKE_ACK_BIT]) || wake_hit
            || (alarm_hit && q.mode.alarm_wake_enable)) begin // see R14 see R15 see R18
            go = 1'b1;
            sel = q.mode.wake_ack_output_select;
        end
        if (go) begin
            unique case (sel) // see R16 see R17
                DRV_HIZ: d.pin_oe = 1'b0;
                DRV_LOW: {d.pin_oe, d.pin} = 2'b10;
                DRV_HIGH: {d.pin_oe, d.pin} = 2'b11;
                DRV_RSV: d.pin_oe = q.pin_oe;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge backup_resetn_i) begin
        if (!backup_resetn_i) begin
            q <= '0;
            q.mode <= pcm_power_mode_s'(POWER_MODE_RST); // see R21
        end else begin
            q <= d;
        end
    end

    assign mode_o = q.mode;
    assign pin_o = q.pin;
    assign pin_oe_o = q.pin_oe;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!backup_resetn_i);

    a_wake_ack_wins: assert property ( // see R15
        (wr_i.cmd_we && wr_i.data[1:0] == 2'b11 && q.mode.wake_ack_output_select == DRV_HIGH)
        |=> (pin_oe_o && pin_o))
        else $error("wake-ack state did not win over power-off");
    a_off_drives_low: assert property ( // see R13
        (wr_i.cmd_we && wr_i.data[1:0] == 2'b01 && !wake_hit && !alarm_hit
         && q.mode.power_off_output_select == DRV_LOW) |=> (pin_oe_o && !pin_o))
        else $error("power-off command did not drive pin low");
    a_alarm_wake_ack: assert property ( // see R18
        (alarm_hit && q.mode.alarm_wake_enable && q.mode.wake_ack_output_select == DRV_HIZ)
        |=> !pin_oe_o)
        else $error("alarm wake did not float the pin");
endmodule : pcm_power_ctl

// ===== testbench/pcm_wake_src.sv
// far-side model: wake-up source, alarm source and the supply input on the alarm pin
`timescale 1ns/1ps
module pcm_wake_src (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic pin_oe_i,
    output logic wake_o,
    output logic alarm_o,
    output logic level_o
);
    // the supply input has an external pull-up and no internal one, so a floated pin reads high
    assign level_o = pin_oe_i ? pin_i : 1'b1;
    initial begin
        wake_o = 1'b0;
        alarm_o = 1'b0;
    end
    // ev 1 toggles the wake line, ev 2 pulses the alarm long enough to cross the synchroniser
    task kick(input int ev);
        @(posedge clk_i);
        if (ev == 1) wake_o <= ~wake_o;
        if (ev == 2) alarm_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        alarm_o <= 1'b0;
    endtask : kick
endmodule : pcm_wake_src

// ===== testbench/tb.sv
// self-checking bench for the power and clock manager
`timescale 1ns/1ps
module tb import pcm_pkg::*; ;
// ==========================================================================
// signals
logic clk_i, resetn_i, backup_resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
logic [7:0] paddr_i;
logic [31:0] pwdata_i, prdata_o, periph_clk_en_o, q;
logic slow_clk_i, osc_clk_i, pll_clk_i, wake_pin_i, rtc_alarm_i, pin_level;
logic main_oscillator_on_o, oscillator_bypass_o, master_clk_o, clock_output_pin_o, clock_output_pin_oe_o;
logic power_off_alarm_pin_o, power_off_alarm_pin_oe_o, oscillator_stable_flag_o, pll_lock_o;
logic [5:0] pll_factor_o;
int n_mismatch, n_compared, cyc, n;
typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} pcm_row_s;
pcm_row_s rows[9] = '{
    '{8'h10, 32'hffff_ffff, 8'h18, PERIPH_MASK},
    '{8'h14, 32'h0000_0004, 8'h18, PERIPH_MASK & ~32'h4},
    '{8'h10, 32'h0000_0000, 8'h18, PERIPH_MASK & ~32'h4},
    '{8'h14, 32'h0000_0000, 8'h18, PERIPH_MASK & ~32'h4},
    '{8'h18, 32'h0000_0000, 8'h18, PERIPH_MASK & ~32'h4},
    '{8'h10, 32'h0000_0004, 8'h18, PERIPH_MASK},
    '{8'h14, 32'hffff_ffff, 8'h18, 32'h0},
    '{8'h20, 32'hffff_3fec, 8'h20, 32'h3fff_3f64},
    '{8'h28, 32'h0000_0000, 8'h28, 32'h0}};
// power mode, command, far-side event, expected {pin enable, pin level}
logic [19:0] pins[13] = '{20'h49113, 20'h49112, 20'h89112, 20'h89113, 20'hc9113, 20'h09112,
    20'h09303, 20'h01201, 20'h09102, 20'h02103, 20'h29222, 20'h39123, 20'h09223};

pcm_clock_manager dut_u (.*);
pcm_wake_src p_u (.clk_i(clk_i), .pin_i(power_off_alarm_pin_o), .pin_oe_i(power_off_alarm_pin_oe_o),
    .wake_o(wake_pin_i), .alarm_o(rtc_alarm_i), .level_o(pin_level));

// ==========================================================================
// clocks, timeout and tasks
initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
end
always #20 slow_clk_i = ~slow_clk_i;
always #10 osc_clk_i = ~osc_clk_i;
always #6 pll_clk_i = ~pll_clk_i;
always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
        n_mismatch++;
        conclude();
    end
end
task conclude();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask : conclude
task chk(input logic [31:0] got, input logic [31:0] ex);
    n_compared++;
    if (got !== ex) begin
        n_mismatch++;
        $display("unexpected at %0t: got %h, expected %h", $time, got, ex);
    end
endtask : chk
// full apb transfer; the request is held until pready is seen high
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
endtask : apb
task pin_case(input logic [19:0] r);
    apb(1'b1, 8'h2c, {24'h0, r[19:12]});
    apb(1'b1, 8'h28, {28'h0, r[11:8]});
    p_u.kick(int'(r[7:4]));
    repeat (6) @(posedge clk_i);
    chk({30'h0, power_off_alarm_pin_oe_o, pin_level}, {28'h0, r[3:0]});
endtask : pin_case
task wait_flag(input int b);
    n = 0;
    while (!(b ? pll_lock_o === 1'b1 : oscillator_stable_flag_o === 1'b1) && n < 400) begin
        @(posedge clk_i);
        n++;
    end
endtask : wait_flag

// ==========================================================================
// main sequence
initial begin
    {resetn_i, backup_resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {slow_clk_i, osc_clk_i, pll_clk_i, cyc, n_mismatch, n_compared} = '0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    backup_resetn_i <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk(q, CLK_STATE_RST);
    apb(1'b0, 8'h2c, 32'h0);
    chk(q, 32'h1);
    for (int i = 0; i < 9; i++) begin
        apb(1'b1, rows[i].wa, rows[i].wd);
        apb(1'b0, rows[i].ra, 32'h0);
        chk(q, rows[i].ex);
    end
    chk({31'h0, clock_output_pin_oe_o}, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 13; i++) pin_case(pins[i]);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    apb(1'b0, 8'h2c, 32'h0);
    chk(q, 32'h9);
    backup_resetn_i <= 1'b0;
    @(posedge clk_i);
    backup_resetn_i <= 1'b1;
    apb(1'b0, 8'h2c, 32'h0);
    chk({q[30:0], power_off_alarm_pin_oe_o}, 32'h2);
    apb(1'b1, 8'h20, 32'h0002_0002); // enable without bypass
    @(negedge clk_i);
    chk({31'h0, clock_output_pin_oe_o}, 32'h1);
    wait_flag(0);
    chk({31'h0, n > 50 && n < 160}, 32'h1);
    apb(1'b1, 8'h20, 32'h0202_0302); // lock count of 2
    @(negedge clk_i);
    chk({26'h0, pll_factor_o}, 32'h3);
    wait_flag(1);
    chk({31'h0, n > 2 && n < 30}, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, 8'h20, 32'h0002_0002);
    repeat (2) @(posedge clk_i);
    chk({31'h0, pll_lock_o}, 32'h0);
    apb(1'b1, 8'h20, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk({29'h0, main_oscillator_on_o, oscillator_bypass_o, oscillator_stable_flag_o}, 32'h2);
    conclude();
end
endmodule : tb
